// file: src/swc_pkg.sv
// swc_pkg: constants and types of the sleep and wake-up controller
// assumes one 50 MHz system clock that also serves as the oscillator
package swc_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int CLK_PERIOD_NS = 20;
   localparam int LF_OSC_HZ = 31_000;
   localparam int LF_DIV = CLK_HZ / LF_OSC_HZ;
   // the oscillator that must start up is the one feeding ref_clk
   localparam int OSC_PERIOD_NS = CLK_PERIOD_NS;
   localparam int STARTUP_OSC_PERIODS = 1024;
   localparam int STARTUP_DELAY_NS = STARTUP_OSC_PERIODS * OSC_PERIOD_NS;
   localparam int OST_CYCLES = (STARTUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OST_W = 11;
   localparam int DIV_W = 11;
   localparam int WD_W = 16;
   localparam int N_IRQ = 8;

   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_IRQ_EN = 8'h08;
   localparam logic [7:0] OFS_STATE = 8'h0c;

   localparam int STATUS_PD_BIT = 3;
   localparam int STATUS_TO_BIT = 4;
   localparam int CTRL_GIE_BIT = 0;
   localparam int CTRL_WDTE_LSB = 1;
   localparam int CTRL_SWDTEN_BIT = 3;
   localparam int CTRL_OSC_LSB = 4;
   localparam int CTRL_EXTRST_EN_BIT = 6;
   localparam int CTRL_BOR_EN_BIT = 7;
   localparam logic [7:0] CTRL_RESET = 8'hc0;
   localparam logic [7:0] IRQ_EN_RESET = 8'h00;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      WDTE_OFF    = 2'b00,
      WDTE_SW     = 2'b01,
      WDTE_NSLEEP = 2'b10,
      WDTE_ON     = 2'b11
   } swc_wdte_e;

   typedef enum logic [1:0] {
      OSC_INTERNAL   = 2'b00,
      OSC_CRYSTAL    = 2'b01,
      OSC_HIGH_SPEED = 2'b10,
      OSC_LOW_POWER  = 2'b11
   } swc_osc_e;

   typedef enum logic [2:0] {
      ST_AWAKE   = 3'b000,
      ST_ENTER   = 3'b001,
      ST_ASLEEP  = 3'b010,
      ST_STARTUP = 3'b011,
      ST_RESUME  = 3'b100
   } swc_state_e;
endpackage

// file: src/swc_top.sv
// swc_top: sleep entry, clock gating, wake-up and status flags with AXI4-Lite access
// assumes core strobes and irq flags are on ref_clk; reset pins are asynchronous
//
// Functional notes
// - sleep is entered only when the core executes the sleep instruction.
// - entering sleep clears the watchdog; it keeps counting if enabled in sleep.
// - completed sleep entry clears the power-down flag and sets the timeout flag.
// - the core clock is stopped while asleep.
// - low-frequency, timer, converter and sensing oscillators keep running in sleep.
// - io pins hold their pre-sleep drive state for the whole sleep.
// - sleep changes no reset source except the watchdog.
// - wake on reset pin, brownout, power-on, watchdog or enabled interrupts.
// - pin, brownout and power-on wakes reset fully; watchdog and interrupts resume.
// - while sleep executes the core prefetches the next instruction.
// - an interrupt wakes only if its own enable is set, ignoring global enable.
// - interrupt wake with global enable off continues after the sleep instruction.
// - with global enable on, run the next instruction then vector.
// - every wake from sleep clears the watchdog.
// - global enable off with enabled flag already set makes sleep a no-op.
// - flag set during or after sleep: complete sleep, then wake at once.
// - crystal, high-speed and low-power modes wait 1024 oscillator periods on wake.
// - watchdog timeout in sleep wakes without reset and records it in the flags.
// - after wake the watchdog stays clear until oscillator start-up ends.
`timescale 1ns/1ns
module swc_top
#(
   parameter logic [15:0] WDT_LIMIT = 16'hffff
)
(
   input  wire logic                       ref_clk,
   input  wire logic                       rst,
   input  wire logic [7:0]                 s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [7:0]                 s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   input  wire logic                       sleep_exec,
   input  wire logic                       wdt_clear_cmd,
   input  wire logic [swc_pkg::N_IRQ-1:0]  irq_flags,
   input  wire logic                       external_reset_pin_n,
   input  wire logic                       brownout_reset,
   input  wire logic                       por_reset,
   output logic                            core_clk_en,
   output logic                            io_hold,
   output logic [3:0]                      osc_keep_run,
   output logic                            asleep,
   output logic                            prefetch_next,
   output logic                            sleep_nop,
   output logic                            wake_resume,
   output logic                            irq_vector_req,
   output logic                            sys_reset
);
   swc_wd_if wd ();

   swc_wdog #(.LIMIT(WDT_LIMIT)) u_wdog
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .wd      (wd.wd)
   );

   // one-hot select {state, irq_en, ctrl, status}; zero means unmapped
   function automatic logic [3:0] reg_sel(input logic [7:0] a);
      logic [3:0] r;
      r = 4'h0;
      if (a == swc_pkg::OFS_STATUS)
         r = 4'h1;
      if (a == swc_pkg::OFS_CTRL)
         r = 4'h2;
      if (a == swc_pkg::OFS_IRQ_EN)
         r = 4'h4;
      if (a == swc_pkg::OFS_STATE)
         r = 4'h8;
      return r;
   endfunction

   swc_pkg::swc_state_e      state_q;
   swc_pkg::swc_state_e      state_d;
   logic [1:0]               ext_sync_q;
   logic [1:0]               bor_sync_q;
   logic [1:0]               por_sync_q;
   logic [7:0]               ctrl_q;
   logic [7:0]               irq_en_q;
   logic                     to_q;
   logic                     pd_q;
   logic                     to_d;
   logic                     pd_d;
   logic [swc_pkg::OST_W-1:0] ost_q;
   logic                     by_irq_q;
   logic                     by_irq_d;
   logic                     wd_wake_q;
   logic                     global_irq_enable;
   logic                     swdten;
   logic                     ext_en;
   logic                     bor_en;
   swc_pkg::swc_wdte_e       wdte;
   swc_pkg::swc_osc_e        osc;
   logic                     osc_slow;
   logic                     wake_req;
   logic                     reset_src;
   logic                     wd_active;
   logic                     sleeping;
   logic                     nop_sleep;
   logic                     sleep_go;
   logic                     wake_now;
   logic                     wd_reset;
   logic                     clk_on_d;

   // reset pins cross in from outside the clock domain
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ext_sync_q <= 2'h3;
         bor_sync_q <= 2'h0;
         por_sync_q <= 2'h0;
      end
      else
      begin
         ext_sync_q <= {ext_sync_q[0], external_reset_pin_n};
         bor_sync_q <= {bor_sync_q[0], brownout_reset};
         por_sync_q <= {por_sync_q[0], por_reset};
      end
   end

   assign global_irq_enable = ctrl_q[swc_pkg::CTRL_GIE_BIT];
   assign swdten = ctrl_q[swc_pkg::CTRL_SWDTEN_BIT];
   assign ext_en = ctrl_q[swc_pkg::CTRL_EXTRST_EN_BIT];
   assign bor_en = ctrl_q[swc_pkg::CTRL_BOR_EN_BIT];
   assign wdte = swc_pkg::swc_wdte_e'(ctrl_q[swc_pkg::CTRL_WDTE_LSB +: 2]);
   assign osc = swc_pkg::swc_osc_e'(ctrl_q[swc_pkg::CTRL_OSC_LSB +: 2]);
   assign osc_slow = (osc != swc_pkg::OSC_INTERNAL);

   // global enable deliberately absent from the wake term
   assign wake_req = |(irq_flags & irq_en_q);
   // same reset path whether asleep or awake
   assign reset_src = (ext_en & ~ext_sync_q[1]) | (bor_en & bor_sync_q[1])
                    | por_sync_q[1];

   assign sleeping = (state_q == swc_pkg::ST_ENTER) || (state_q == swc_pkg::ST_ASLEEP);
   assign wd_active = (wdte == swc_pkg::WDTE_ON)
                    || (wdte == swc_pkg::WDTE_NSLEEP && !sleeping)
                    || (wdte == swc_pkg::WDTE_SW && swdten);

   assign nop_sleep = (state_q == swc_pkg::ST_AWAKE) && sleep_exec && !global_irq_enable
                    && wake_req;
   assign sleep_go = (state_q == swc_pkg::ST_AWAKE) && sleep_exec && !nop_sleep;
   // a flag arriving while entry completes wakes right away
   assign wake_now = sleeping && (wake_req || wd.timeout);
   assign wd_reset = wd.timeout && !sleeping;
   assign by_irq_d = wake_now ? wake_req : by_irq_q;

   assign wd.run = wd_active;
   assign wd.clear = sleep_go || (state_q == swc_pkg::ST_ENTER) || wake_now
                   || (state_q == swc_pkg::ST_STARTUP) || wdt_clear_cmd
                   || !wd_active;

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         swc_pkg::ST_AWAKE:
            if (sleep_go)
               state_d = swc_pkg::ST_ENTER;
         swc_pkg::ST_ENTER, swc_pkg::ST_ASLEEP:
            if (wake_now)
               state_d = osc_slow ? swc_pkg::ST_STARTUP : swc_pkg::ST_RESUME;
            else
               state_d = swc_pkg::ST_ASLEEP;
         swc_pkg::ST_STARTUP:
            if (ost_q == '0)
               state_d = swc_pkg::ST_RESUME;
         swc_pkg::ST_RESUME:
            state_d = swc_pkg::ST_AWAKE;
         default:
            state_d = swc_pkg::ST_AWAKE;
      endcase
   end

   // watchdog timeout outranks the entry update so the event is recorded
   assign to_d = wd.timeout ? 1'b0
               : ((state_q == swc_pkg::ST_ENTER) || wdt_clear_cmd) ? 1'b1
               : to_q;
   assign pd_d = wd.timeout ? pd_q
               : (state_q == swc_pkg::ST_ENTER) ? 1'b0
               : wdt_clear_cmd ? 1'b1 : pd_q;
   assign clk_on_d = (state_d == swc_pkg::ST_AWAKE) || (state_d == swc_pkg::ST_RESUME);

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state_q <= swc_pkg::ST_AWAKE;
         to_q <= 1'b1;
         pd_q <= 1'b1;
         by_irq_q <= 1'b0;
         wd_wake_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         to_q <= to_d;
         pd_q <= pd_d;
         by_irq_q <= by_irq_d;
         wd_wake_q <= wake_now ? (wd.timeout && !wake_req) : wd_wake_q;
      end
   end

   // start-up count runs only for external oscillator modes
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         ost_q <= '0;
      else if (wake_now && osc_slow)
         ost_q <= swc_pkg::OST_W'(swc_pkg::OST_CYCLES - 1);
      else if (state_q == swc_pkg::ST_STARTUP)
         ost_q <= ost_q - 1'b1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         core_clk_en <= 1'b1;
         io_hold <= 1'b0;
         asleep <= 1'b0;
         osc_keep_run <= 4'hf;
         prefetch_next <= 1'b0;
         sleep_nop <= 1'b0;
         wake_resume <= 1'b0;
         irq_vector_req <= 1'b0;
         sys_reset <= 1'b0;
      end
      else
      begin
         core_clk_en <= clk_on_d;
         io_hold <= !clk_on_d;
         asleep <= (state_d == swc_pkg::ST_ASLEEP);
         osc_keep_run <= 4'hf;
         prefetch_next <= (state_q == swc_pkg::ST_AWAKE) && sleep_exec;
         sleep_nop <= nop_sleep;
         wake_resume <= (state_d == swc_pkg::ST_RESUME);
         irq_vector_req <= (state_d == swc_pkg::ST_RESUME) && global_irq_enable && by_irq_d;
         sys_reset <= reset_src || wd_reset;
      end
   end

   // register bus: write address and data taken in either order
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        aw_hold_q;
   logic        w_hold_q;
   logic        aw_take;
   logic        w_take;
   logic        aw_full;
   logic        w_full;
   logic        do_wr;
   logic        bvalid_d;
   logic        rvalid_d;
   logic        ar_take;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic [3:0]  wr_sel;
   logic [3:0]  rd_sel;
   logic [7:0]  status_rd;
   logic [7:0]  rd_byte;

   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign aw_full = aw_hold_q || aw_take;
   assign w_full = w_hold_q || w_take;
   assign do_wr = aw_full && w_full && !s_axi_bvalid;
   assign bvalid_d = do_wr || (s_axi_bvalid && !s_axi_bready);
   assign wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr;
   assign wr_data = w_hold_q ? wdata_q : s_axi_wdata;
   assign wr_strb = w_hold_q ? wstrb_q : s_axi_wstrb;
   assign wr_sel = reg_sel(wr_addr);
   assign ar_take = s_axi_arvalid && s_axi_arready;
   assign rvalid_d = ar_take || (s_axi_rvalid && !s_axi_rready);
   assign rd_sel = reg_sel(s_axi_araddr);

   always_comb
   begin
      status_rd = 8'h00;
      status_rd[swc_pkg::STATUS_TO_BIT] = to_q;
      status_rd[swc_pkg::STATUS_PD_BIT] = pd_q;
   end

   assign rd_byte = rd_sel[0] ? status_rd
                  : rd_sel[1] ? ctrl_q
                  : rd_sel[2] ? irq_en_q
                  : rd_sel[3] ? {3'h0, by_irq_q, wd_wake_q, state_q}
                  : 8'h00;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= swc_pkg::RESP_OKAY;
      end
      else
      begin
         aw_hold_q <= aw_full && !do_wr;
         w_hold_q <= w_full && !do_wr;
         s_axi_awready <= !(aw_full && !do_wr) && !bvalid_d;
         s_axi_wready <= !(w_full && !do_wr) && !bvalid_d;
         s_axi_bvalid <= bvalid_d;
         if (do_wr)
            s_axi_bresp <= (wr_sel != 4'h0) ? swc_pkg::RESP_OKAY : swc_pkg::RESP_SLVERR;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (aw_take)
         awaddr_q <= s_axi_awaddr;
      if (w_take)
      begin
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end
   end

   // status and state are read-only; writes to them are accepted and dropped
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ctrl_q <= swc_pkg::CTRL_RESET;
         irq_en_q <= swc_pkg::IRQ_EN_RESET;
      end
      else if (do_wr && wr_strb[0])
      begin
         if (wr_sel[1])
            ctrl_q <= wr_data[7:0];
         if (wr_sel[2])
            irq_en_q <= wr_data[7:0];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= swc_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !rvalid_d;
         s_axi_rvalid <= rvalid_d;
         if (ar_take)
         begin
            s_axi_rdata <= {24'h0, rd_byte};
            s_axi_rresp <= (rd_sel != 4'h0) ? swc_pkg::RESP_OKAY : swc_pkg::RESP_SLVERR;
         end
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_nop_sleep;
      nop_sleep && !wdt_clear_cmd;
   endsequence
   sequence s_sleep_wake;
      state_q == swc_pkg::ST_ASLEEP ##0 wake_req;
   endsequence
   sequence s_fast_wake;
      s_sleep_wake ##0 !osc_slow;
   endsequence

   a_sleep_only_instr: assert property (
      state_q == swc_pkg::ST_AWAKE && !sleep_exec |=> state_q != swc_pkg::ST_ENTER)
      else $error("sleep entered without instruction");
   a_entry_flags_set: assert property (
      state_q == swc_pkg::ST_ENTER && !wd.timeout |=> to_q && !pd_q)
      else $error("entry flags wrong");
   a_core_clk_gated: assert property (
      sleeping |-> !core_clk_en)
      else $error("core clock running in sleep");
   a_io_hold_kept: assert property (
      $rose(io_hold) |-> state_q == swc_pkg::ST_ENTER ##1 (io_hold || wake_resume))
      else $error("io hold not held");
   a_irq_wake_go: assert property (
      s_sleep_wake |=> state_q inside {swc_pkg::ST_STARTUP, swc_pkg::ST_RESUME})
      else $error("enabled irq did not wake");
   a_reset_src_out: assert property (
      reset_src |=> sys_reset)
      else $error("reset source not passed");
   a_prefetch_next: assert property (
      sleep_exec && state_q == swc_pkg::ST_AWAKE |=> prefetch_next)
      else $error("no prefetch on sleep");
   a_vector_after_wake: assert property (
      s_fast_wake ##0 $stable(global_irq_enable) |=> wake_resume && (irq_vector_req == global_irq_enable) ##1 !wake_resume)
      else $error("resume or vector wrong");
   a_wake_clears_wd: assert property (
      wake_now |=> wd.count == '0)
      else $error("watchdog not cleared on wake");
   a_sleep_nop_flags: assert property (
      s_nop_sleep |=> sleep_nop && state_q == swc_pkg::ST_AWAKE && $stable(to_q) && $stable(pd_q))
      else $error("sleep no-op changed state");
   a_late_flag_wake: assert property (
      state_q == swc_pkg::ST_ENTER && wake_req |=> !pd_q && to_q && !sleeping)
      else $error("late flag did not wake at once");
   a_ost_length: assert property (
      wake_now && osc_slow |=> state_q == swc_pkg::ST_STARTUP ##0 ost_q == 11'h3ff)
      else $error("start-up count wrong");
   a_ost_end: assert property (
      state_q == swc_pkg::ST_STARTUP && ost_q == '0 |=> wake_resume)
      else $error("start-up did not end");
   a_wd_sleep_wake: assert property (
      state_q == swc_pkg::ST_ASLEEP && wd.timeout |=> !to_q && !sleeping ##1 !sys_reset || reset_src)
      else $error("watchdog sleep wake wrong");
   a_ost_wd_clear: assert property (
      state_q == swc_pkg::ST_STARTUP |=> wd.count == '0)
      else $error("watchdog ran during start-up");
endmodule

// file: src/swc_wd_if.sv
// swc_wd_if: link between the sleep sequencer and its watchdog counter
// assumes both ends run on ref_clk
`timescale 1ns/1ns
interface swc_wd_if;
   logic                      clear;
   logic                      run;
   logic                      timeout;
   logic [swc_pkg::WD_W-1:0]  count;
   modport ctl (output clear, output run, input timeout, input count);
   modport wd (input clear, input run, output timeout, output count);
endinterface

// file: src/swc_wdog.sv
// swc_wdog: watchdog counter ticking on the low-frequency oscillator rate
// assumes clear and run come from the sequencer on the same clock
`timescale 1ns/1ns
module swc_wdog
#(
   parameter logic [15:0] LIMIT = 16'hffff
)
(
   input wire logic  ref_clk,
   input wire logic  rst,
   swc_wd_if.wd      wd
);
   localparam logic [swc_pkg::DIV_W-1:0] DIV_LAST = swc_pkg::DIV_W'(swc_pkg::LF_DIV - 1);

   logic [swc_pkg::DIV_W-1:0] div_q;
   logic [swc_pkg::WD_W-1:0]  count_q;
   logic                      timeout_q;
   logic                      lf_tick;
   logic                      at_limit;

   // the low-frequency tick free-runs, sleep or not
   assign lf_tick = (div_q == DIV_LAST);
   assign at_limit = (count_q == LIMIT);
   assign wd.timeout = timeout_q;
   assign wd.count = count_q;

   always_ff @(posedge ref_clk)
   begin
      if (rst || lf_tick)
         div_q <= '0;
      else
         div_q <= div_q + 1'b1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst || wd.clear)
         count_q <= '0;
      else if (wd.run && lf_tick)
         count_q <= at_limit ? '0 : count_q + 1'b1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         timeout_q <= 1'b0;
      else
         timeout_q <= wd.run && !wd.clear && lf_tick && at_limit;
   end

   a_wd_clear_zero: assert property (@(posedge ref_clk) disable iff (rst)
      wd.clear |=> wd.count == '0)
      else $error("watchdog not cleared");
   a_wd_stopped_hold: assert property (@(posedge ref_clk) disable iff (rst)
      !wd.clear && !(wd.run && lf_tick) |=> $stable(wd.count) && !wd.timeout)
      else $error("stopped watchdog moved");
endmodule

// file: tb/swc_core_model.sv
// swc_core_model: stand-in for the core issuing the sleep instruction
// assumes the bench requests sleeps on ref_clk
`timescale 1ns/1ns
module swc_core_model
(
   input  wire logic  sleep_cmd,
   input  wire logic  core_clk_en,
   output logic       sleep_exec
);
   // a stopped core executes nothing, so the slot after sleep acts as a no-op
   assign sleep_exec = sleep_cmd & core_clk_en;
endmodule

// file: tb/tb.sv
// tb: sleep entry, wake-up and status flags through the core pins and AXI4-Lite
// assumes swc_top with a short watchdog limit and the core model
`timescale 1ns/1ns
module tb;
   logic        ref_clk = 0, rst = 1, sleep_cmd = 0, sleep_exec, wdt_clear_cmd = 0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, brownout_reset = 0, por_reset = 0;
   logic        external_reset_pin_n = 1, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, core_clk_en, io_hold, asleep;
   logic        prefetch_next, sleep_nop, wake_resume, irq_vector_req, sys_reset;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, irq_flags = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_v;
   logic [3:0]  s_axi_wstrb = 4'hf, osc_keep_run;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r, wr_b;
   int          errors = 0, checks_done = 0, n;
   swc_top #(.WDT_LIMIT(16'h0002)) swc_top_i (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_exec, .wdt_clear_cmd, .irq_flags,
      .external_reset_pin_n, .brownout_reset, .por_reset, .core_clk_en, .io_hold,
      .osc_keep_run, .asleep, .prefetch_next, .sleep_nop, .wake_resume, .irq_vector_req,
      .sys_reset);
   swc_core_model swc_core_model_i (.sleep_cmd, .core_clk_en, .sleep_exec);
   initial
   begin
      forever #10 ref_clk = ~ref_clk;
   end
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task tally_and_finish;
      if (errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
      end
      while (s_axi_bvalid !== 1'b1);
      wr_b = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge ref_clk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
      do
      begin
         @(posedge ref_clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
      end
      while (s_axi_rvalid !== 1'b1);
      {rd_v, rd_r} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 0;
   endtask
   // leaves the bench one step into the cycle after the sleep was taken
   task pulse_sleep;
      @(posedge ref_clk) sleep_cmd <= 1;
      @(posedge ref_clk) sleep_cmd <= 0;
      #1;
   endtask
   task wait_wake;
      n = 0;
      while (wake_resume !== 1'b1 && n < 10000)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk("woke", wake_resume, 1);
   endtask
   task t_reset_vals;
      rd(swc_pkg::OFS_CTRL); chk("ctrl", rd_v, 32'h000000c0);
      rd(swc_pkg::OFS_STATUS); chk("status", rd_v, 32'h00000018);
      rd(8'h20); chk("unmapped", {rd_v[29:0], rd_r}, {30'h0, swc_pkg::RESP_SLVERR});
      wr(8'h20, 32'h0);
      chk("bresp_unmapped", wr_b, swc_pkg::RESP_SLVERR);
   endtask
   task t_irq_wake;
      wr(swc_pkg::OFS_IRQ_EN, 32'h04); wr(swc_pkg::OFS_CTRL, 32'h01);
      chk("bresp_ok", wr_b, swc_pkg::RESP_OKAY);
      pulse_sleep;
      chk("prefetch", prefetch_next, 1);
      chk("clk_en", core_clk_en, 0);
      chk("io_hold", io_hold, 1);
      chk("osc", osc_keep_run, 4'hf);
      @(posedge ref_clk) irq_flags <= 8'h01;
      #1 chk("asleep", asleep, 1);
      rd(swc_pkg::OFS_STATUS); chk("status_sleep", rd_v, 32'h10);
      chk("masked", asleep, 1);
      @(posedge ref_clk) irq_flags <= 8'h04;
      wait_wake;
      chk("wake_lat", n, 1);
      chk("vector", irq_vector_req, 1);
      chk("clk_back", core_clk_en, 0 + 1);
      @(posedge ref_clk) irq_flags <= 8'h00;
   endtask
   task t_nop_and_startup;
      wr(swc_pkg::OFS_CTRL, 32'h00);
      @(posedge ref_clk) {wdt_clear_cmd, irq_flags} <= {1'b1, 8'h04};
      @(posedge ref_clk) wdt_clear_cmd <= 0;
      pulse_sleep;
      chk("nop", {sleep_nop, core_clk_en}, 2'b11);
      rd(swc_pkg::OFS_STATUS); chk("status_nop", rd_v, 32'h18);
      @(posedge ref_clk) irq_flags <= 8'h00;
      // flag rises in the entry cycle; watchdog on so start-up must hold it clear
      wr(swc_pkg::OFS_CTRL, 32'h96);
      @(posedge ref_clk) sleep_cmd <= 1;
      @(posedge ref_clk) {sleep_cmd, irq_flags} <= {1'b0, 8'h04};
      wait_wake;
      chk("startup", n, swc_pkg::STARTUP_OSC_PERIODS + 1);
      chk("inline", irq_vector_req, 0);
      @(posedge ref_clk) irq_flags <= 8'h00;
      rd(swc_pkg::OFS_STATUS); chk("status_late", rd_v, 32'h10);
   endtask
   task t_bor_and_wdog;
      wr(swc_pkg::OFS_CTRL, 32'h80);
      pulse_sleep;
      @(posedge ref_clk) brownout_reset <= 1;
      repeat (3) @(posedge ref_clk);
      #1 chk("bor_reset", sys_reset, 1);
      @(posedge ref_clk) {brownout_reset, rst} <= 2'b01;
      repeat (8) @(posedge ref_clk);
      rst <= 0;
      wr(swc_pkg::OFS_CTRL, 32'h06);
      pulse_sleep;
      wait_wake;
      chk("wd_wake", {wake_resume, irq_vector_req, sys_reset}, 3'b100);
      rd(swc_pkg::OFS_STATUS); chk("status_wd", rd_v, 32'h00);
      rd(swc_pkg::OFS_STATE);
      chk("state_wd", rd_v, 32'h08);
   endtask
   initial
   begin
      #400_000;
      errors++;
      tally_and_finish;
   end
   initial
   begin
      repeat (8) @(posedge ref_clk);
      rst <= 0;
      t_reset_vals;
      t_irq_wake;
      t_nop_and_startup;
      t_bor_and_wdog;
      tally_and_finish;
   end
endmodule
